// *** design/ccs_pkg.sv ***
// What this block does
// - Fast-clock calibration times four slow-oscillator periods.
// - Fast-clock interval: triggers between calibrations, zero off.
// - Store raw fast-clock result in result register.
// - Never scale results; firmware applies correction.
// - Fast oscillator powered only during measurements.
// - Amplitude interval: sequence cycles per measurement, zero off.
// - Peak detection stops at wave 1..31, zero off.
// - Amplitude measurements per amplitude calibration, zero off.
// - Each calibration measures reference and half reference.
// - Peak discharge to reference is timed as amplitude.
// - Amplitude results land at fixed buffer words.
// - Offset calibration once after power-on, then periodic.
// - Offset calibration overwrites the zero-cross threshold.
// - Ring oscillator calibrated before every converter measurement.
// - Results are 16.16 fast-oscillator period words.
// - Fast-clock calibration by sequencer or host command.
// - Update flag reads one after a new result.
`default_nettype none

package ccs_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int RATE_W = 3;
  localparam int CNT_W  = 7;
  localparam int PD_W   = 5;
  localparam int ZCD_W  = 8;
  localparam int EV_W   = 4;
  localparam int SPAN_W = 3;

  localparam logic [ADDR_W-1:0] CLOCK_POWER_CONFIG_ADDR    = 10'h0c5;
  localparam logic [ADDR_W-1:0] FRONTEND_CAL_CONFIG_ADDR   = 10'h0c9;
  localparam logic [ADDR_W-1:0] AMPLITUDE_CONFIG_ADDR      = 10'h0cb;
  localparam logic [ADDR_W-1:0] FAST_CLOCK_CAL_RESULT_ADDR = 10'h0e4;
  localparam logic [ADDR_W-1:0] AMPLITUDE_UP_RESULT_ADDR   = 10'h082;
  localparam logic [ADDR_W-1:0] AMPLITUDE_CAL_HIGH_ADDR    = 10'h083;
  localparam logic [ADDR_W-1:0] AMPLITUDE_DOWN_RESULT_ADDR = 10'h086;
  localparam logic [ADDR_W-1:0] AMPLITUDE_CAL_LOW_ADDR     = 10'h087;
  localparam logic [ADDR_W-1:0] ZERO_CROSS_THRESHOLD_ADDR  = 10'h0d0;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR            = 10'h0d1;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR              = 10'h0d2;
  localparam logic [ADDR_W-1:0] COMMAND_ADDR               = 10'h0d3;

  localparam int FAST_CLOCK_CAL_INTERVAL_LSB = 0;
  localparam int OFFSET_CAL_INTERVAL_LSB     = 0;
  localparam int AMPLITUDE_MEAS_INTERVAL_LSB = 0;
  localparam int PEAK_DETECT_LAST_WAVE_LSB   = 4;
  localparam int AMPLITUDE_CAL_INTERVAL_LSB  = 12;
  localparam int CMD_FAST_CLOCK_CAL_BIT      = 0;

  localparam int EV_FAST_CLOCK_CAL_UPDATED = 0;
  localparam int EV_AMPLITUDE_DONE         = 1;
  localparam int EV_AMPLITUDE_CAL_DONE     = 2;
  localparam int EV_OFFSET_CAL_DONE        = 3;

  localparam int IDX_FAST = 0;
  localparam int IDX_AMP  = 1;
  localparam int IDX_OFS  = 2;

  localparam logic [DATA_W-1:0] CONFIG_RESET    = 32'h0000_0000;
  localparam logic [ZCD_W-1:0]  ZCD_RESET       = 8'h00;
  localparam logic [2:0]        PENDING_RESET   = 3'h4;
  localparam logic [SPAN_W-1:0] SLOW_PERIODS    = 3'h4;

  typedef enum logic [2:0] {
    OP_FAST_CLOCK,
    OP_OFFSET_CAL,
    OP_CAL_HIGH,
    OP_CAL_LOW,
    OP_AMP_UP,
    OP_AMP_DOWN
  } ccs_op_e;

  // Interval codes 0..7 stand for off, 1, 2, 5, 10, 20, 50 and 100.
  function automatic logic [CNT_W-1:0] ccs_interval(input logic [RATE_W-1:0] code);
    unique case (code)
      3'h0: ccs_interval = 7'h00;
      3'h1: ccs_interval = 7'h01;
      3'h2: ccs_interval = 7'h02;
      3'h3: ccs_interval = 7'h05;
      3'h4: ccs_interval = 7'h0a;
      3'h5: ccs_interval = 7'h14;
      3'h6: ccs_interval = 7'h32;
      3'h7: ccs_interval = 7'h64;
    endcase
  endfunction

endpackage

`default_nettype wire

// *** design/ccs_chip_calibration_scheduler.sv ***
// The implementer's own choice: the strobed register port.
`default_nettype none

module ccs_chip_calibration_scheduler (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic [ccs_pkg::ADDR_W-1:0] addr,
  input  wire logic [ccs_pkg::DATA_W-1:0] wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [ccs_pkg::DATA_W-1:0] rd_data,
  output logic                          irq,
  input  wire logic                     seq_trigger,
  output logic                          fast_osc_enable,
  input  wire logic                     fast_osc_ready,
  output logic                          ring_cal_req,
  input  wire logic                     ring_cal_done,
  output logic                          meas_req,
  output ccs_pkg::ccs_op_e              meas_op,
  output logic      [ccs_pkg::SPAN_W-1:0] slow_period_span,
  input  wire logic                     meas_done,
  input  wire logic [ccs_pkg::DATA_W-1:0] meas_result,
  output logic      [ccs_pkg::PD_W-1:0]   peak_detect_last_wave,
  output logic      [ccs_pkg::ZCD_W-1:0]  zero_cross_threshold
);
  import ccs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    S_IDLE,
    S_WAKE,
    S_RING,
    S_MEAS
  } ccs_state_e;

  typedef struct packed {
    ccs_state_e                  state;
    ccs_op_e                     op;
    logic [DATA_W-1:0]           clock_power_config;
    logic [DATA_W-1:0]           frontend_cal_config;
    logic [DATA_W-1:0]           amplitude_config;
    logic [DATA_W-1:0]           fast_clock_cal_result;
    logic [DATA_W-1:0]           amplitude_up_result;
    logic [DATA_W-1:0]           amplitude_cal_high;
    logic [DATA_W-1:0]           amplitude_down_result;
    logic [DATA_W-1:0]           amplitude_cal_low;
    logic [ZCD_W-1:0]            zct;
    logic [EV_W-1:0]             irq_status;
    logic [EV_W-1:0]             irq_mask;
    logic [2:0][CNT_W-1:0]       seq_cnt;
    logic [CNT_W-1:0]            amc_cnt;
    logic [2:0]                  pending;
    logic [DATA_W-1:0]           rd_data;
  } ccs_state_s;

  ccs_state_s r_reg;
  ccs_state_s r_next;

  logic [2:0][CNT_W-1:0] limit;
  logic [CNT_W-1:0]      amc_limit;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    limit[IDX_FAST] = ccs_interval(r_reg.clock_power_config[FAST_CLOCK_CAL_INTERVAL_LSB +: RATE_W]);
    limit[IDX_AMP]  = ccs_interval(r_reg.amplitude_config[AMPLITUDE_MEAS_INTERVAL_LSB +: RATE_W]);
    limit[IDX_OFS]  = ccs_interval(r_reg.frontend_cal_config[OFFSET_CAL_INTERVAL_LSB +: RATE_W]);
    amc_limit       = ccs_interval(r_reg.amplitude_config[AMPLITUDE_CAL_INTERVAL_LSB +: RATE_W]);
  end

  always_comb begin
    r_next = r_reg;

    // Reads are answered one cycle later from a register.
    r_next.rd_data = '0;
    if (rd_en) begin
      unique case (addr)
        CLOCK_POWER_CONFIG_ADDR:    r_next.rd_data = r_reg.clock_power_config;
        FRONTEND_CAL_CONFIG_ADDR:   r_next.rd_data = r_reg.frontend_cal_config;
        AMPLITUDE_CONFIG_ADDR:      r_next.rd_data = r_reg.amplitude_config;
        FAST_CLOCK_CAL_RESULT_ADDR: r_next.rd_data = r_reg.fast_clock_cal_result;
        AMPLITUDE_UP_RESULT_ADDR:   r_next.rd_data = r_reg.amplitude_up_result;
        AMPLITUDE_CAL_HIGH_ADDR:    r_next.rd_data = r_reg.amplitude_cal_high;
        AMPLITUDE_DOWN_RESULT_ADDR: r_next.rd_data = r_reg.amplitude_down_result;
        AMPLITUDE_CAL_LOW_ADDR:     r_next.rd_data = r_reg.amplitude_cal_low;
        ZERO_CROSS_THRESHOLD_ADDR:  r_next.rd_data = {{(DATA_W-ZCD_W){1'b0}}, r_reg.zct};
        IRQ_STATUS_ADDR:            r_next.rd_data = {{(DATA_W-EV_W){1'b0}}, r_reg.irq_status};
        IRQ_MASK_ADDR:              r_next.rd_data = {{(DATA_W-EV_W){1'b0}}, r_reg.irq_mask};
        default:                    r_next.rd_data = '0;
      endcase
    end

    if (wr_en) begin
      unique case (addr)
        CLOCK_POWER_CONFIG_ADDR:   r_next.clock_power_config = wr_data;
        FRONTEND_CAL_CONFIG_ADDR:  r_next.frontend_cal_config = wr_data;
        AMPLITUDE_CONFIG_ADDR:     r_next.amplitude_config = wr_data;
        ZERO_CROSS_THRESHOLD_ADDR: r_next.zct = wr_data[ZCD_W-1:0];
        IRQ_STATUS_ADDR:           r_next.irq_status = r_reg.irq_status & ~wr_data[EV_W-1:0];
        IRQ_MASK_ADDR:             r_next.irq_mask = wr_data[EV_W-1:0];
        COMMAND_ADDR: begin
          if (wr_data[CMD_FAST_CLOCK_CAL_BIT]) begin
            r_next.pending[IDX_FAST] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Each interval counter restarts once it reaches its setting.
    for (int i = 0; i < 3; i++) begin
      if (limit[i] == '0) begin
        r_next.seq_cnt[i] = '0;
      end else if (seq_trigger) begin
        if (r_reg.seq_cnt[i] + 7'h01 >= limit[i]) begin
          r_next.seq_cnt[i] = '0;
          r_next.pending[i] = 1'b1;
        end else begin
          r_next.seq_cnt[i] = r_reg.seq_cnt[i] + 7'h01;
        end
      end
    end

    unique case (r_reg.state)
      S_IDLE: begin
        // Offset calibration goes first so the threshold is valid before any echo work.
        if (r_reg.pending[IDX_OFS]) begin
          r_next.pending[IDX_OFS] = 1'b0;
          r_next.op = OP_OFFSET_CAL;
          r_next.state = S_WAKE;
        end else if (r_reg.pending[IDX_FAST]) begin
          r_next.pending[IDX_FAST] = 1'b0;
          r_next.op = OP_FAST_CLOCK;
          r_next.state = S_WAKE;
        end else if (r_reg.pending[IDX_AMP]) begin
          r_next.pending[IDX_AMP] = 1'b0;
          r_next.state = S_WAKE;
          r_next.op = OP_AMP_UP;
          if (amc_limit == '0) begin
            r_next.amc_cnt = '0;
          end else if (r_reg.amc_cnt + 7'h01 >= amc_limit) begin
            r_next.amc_cnt = '0;
            r_next.op = OP_CAL_HIGH;
          end else begin
            r_next.amc_cnt = r_reg.amc_cnt + 7'h01;
          end
        end
      end
      S_WAKE: begin
        if (fast_osc_ready) begin
          r_next.state = S_RING;
        end
      end
      S_RING: begin
        if (ring_cal_done) begin
          r_next.state = S_MEAS;
        end
      end
      S_MEAS: begin
        if (meas_done) begin
          // Results are stored raw; firmware scales them when it needs absolute time.
          unique case (r_reg.op)
            OP_FAST_CLOCK: begin
              r_next.fast_clock_cal_result = meas_result;
              r_next.irq_status[EV_FAST_CLOCK_CAL_UPDATED] = 1'b1;
              r_next.state = S_IDLE;
            end
            OP_OFFSET_CAL: begin
              r_next.zct = meas_result[ZCD_W-1:0];
              r_next.irq_status[EV_OFFSET_CAL_DONE] = 1'b1;
              r_next.state = S_IDLE;
            end
            OP_CAL_HIGH: begin
              r_next.amplitude_cal_high = meas_result;
              r_next.op = OP_CAL_LOW;
              r_next.state = S_RING;
            end
            OP_CAL_LOW: begin
              r_next.amplitude_cal_low = meas_result;
              r_next.irq_status[EV_AMPLITUDE_CAL_DONE] = 1'b1;
              r_next.op = OP_AMP_UP;
              r_next.state = S_RING;
            end
            OP_AMP_UP: begin
              r_next.amplitude_up_result = meas_result;
              r_next.op = OP_AMP_DOWN;
              r_next.state = S_RING;
            end
            OP_AMP_DOWN: begin
              r_next.amplitude_down_result = meas_result;
              r_next.irq_status[EV_AMPLITUDE_DONE] = 1'b1;
              r_next.state = S_IDLE;
            end
            default: begin
              r_next.state = S_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_reg <= '0;
      r_reg.clock_power_config <= CONFIG_RESET;
      r_reg.frontend_cal_config <= CONFIG_RESET;
      r_reg.amplitude_config <= CONFIG_RESET;
      r_reg.zct <= ZCD_RESET;
      r_reg.pending <= PENDING_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // The oscillator drops as soon as a job ends, trading a settling wait per job for idle power.
  assign fast_osc_enable       = (r_reg.state != S_IDLE);
  assign ring_cal_req          = (r_reg.state == S_RING);
  assign meas_req              = (r_reg.state == S_MEAS);
  assign meas_op               = r_reg.op;
  assign slow_period_span      = (r_reg.op == OP_FAST_CLOCK) ? SLOW_PERIODS : '0;
  assign peak_detect_last_wave = r_reg.amplitude_config[PEAK_DETECT_LAST_WAVE_LSB +: PD_W];
  assign zero_cross_threshold  = r_reg.zct;
  assign rd_data               = r_reg.rd_data;
  assign irq                   = |(r_reg.irq_status & r_reg.irq_mask);

endmodule

`default_nettype wire

// *** tb/ccs_cal_properties.sv ***
`default_nettype none
module ccs_checker (
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic [ccs_pkg::ADDR_W-1:0] addr,
  input wire logic [ccs_pkg::DATA_W-1:0] wr_data,
  input wire logic                       wr_en,
  input wire logic                       fast_osc_enable,
  input wire logic                       ring_cal_req,
  input wire logic                       ring_cal_done,
  input wire logic                       meas_req,
  input wire ccs_pkg::ccs_op_e           meas_op,
  input wire logic [ccs_pkg::SPAN_W-1:0] slow_period_span,
  input wire logic                       meas_done,
  input wire logic [ccs_pkg::DATA_W-1:0] meas_result,
  input wire logic [ccs_pkg::PD_W-1:0]   peak_detect_last_wave,
  input wire logic [ccs_pkg::ZCD_W-1:0]  zero_cross_threshold
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence ring_end_s;
    ring_cal_req && ring_cal_done;
  endsequence
  sequence ofs_end_s;
    meas_req && meas_done && meas_op == OP_OFFSET_CAL;
  endsequence
  ////////////////////////////////////////////////////////////////
  span_four_a: assert property (meas_req && meas_op == OP_FAST_CLOCK |-> slow_period_span == SLOW_PERIODS)
    else $error("span not four");
  osc_on_a: assert property (ring_cal_req || meas_req |-> fast_osc_enable)
    else $error("oscillator off in use");
  osc_off_a: assert property ($fell(fast_osc_enable) |-> $past(meas_done))
    else $error("oscillator off early");
  ring_step_a: assert property (ring_end_s |=> meas_req && !ring_cal_req)
    else $error("no measure after ring");
  ring_hold_a: assert property (ring_cal_req && !ring_cal_done |=> ring_cal_req)
    else $error("ring request dropped");
  meas_first_a: assert property ($rose(meas_req) |-> $past(ring_cal_req))
    else $error("measure without ring");
  zcd_write_a: assert property (ofs_end_s |=> zero_cross_threshold == 8'($past(meas_result)))
    else $error("threshold not written");
  meas_hold_a: assert property (meas_req && !meas_done |=> meas_req)
    else $error("measure dropped");
  pd_field_a: assert property (wr_en && addr == AMPLITUDE_CONFIG_ADDR |=>
    peak_detect_last_wave == 5'($past(wr_data) >> 4))
    else $error("last wave field wrong");
endmodule

bind ccs_chip_calibration_scheduler ccs_checker ccs_checker_inst (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .fast_osc_enable(fast_osc_enable), .ring_cal_req(ring_cal_req), .ring_cal_done(ring_cal_done),
  .meas_req(meas_req), .meas_op(meas_op), .slow_period_span(slow_period_span), .meas_done(meas_done),
  .meas_result(meas_result), .peak_detect_last_wave(peak_detect_last_wave),
  .zero_cross_threshold(zero_cross_threshold));
`default_nettype wire

// *** tb/ccs_frontend_model.sv ***
`default_nettype none
module ccs_frontend_model (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       stall,
  input  wire logic                       fast_osc_enable,
  input  wire logic                       ring_cal_req,
  input  wire logic                       meas_req,
  input  wire ccs_pkg::ccs_op_e           meas_op,
  output logic                            fast_osc_ready,
  output logic                            ring_cal_done,
  output logic                            meas_done,
  output logic      [ccs_pkg::DATA_W-1:0] meas_result
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccs_pkg::*;
  localparam logic [DATA_W-1:0] NOMINAL = 32'h01e8_4800;
  // Stall holds every done back, so the design must keep asking.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_osc_ready <= 1'b0;
      ring_cal_done  <= 1'b0;
      meas_done      <= 1'b0;
    end else begin
      fast_osc_ready <= fast_osc_enable;
      ring_cal_done  <= ring_cal_req && !ring_cal_done && !stall;
      meas_done      <= meas_req && !meas_done && !stall;
    end
  end
  // The op code in the fraction tells the words apart; outside done the bus shows junk.
  assign meas_result = meas_done ? NOMINAL + 32'(meas_op) : ~(NOMINAL + 32'(meas_op));
endmodule
`default_nettype wire

// *** tb/ccs_chip_calibration_scheduler_bench.sv ***
`default_nettype none
module ccs_chip_calibration_scheduler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ccs_pkg::*;
  localparam logic [DATA_W-1:0] NOMINAL = 32'h01e8_4800;
  localparam logic [ADDR_W-1:0] AMP_ADDR [4] = '{AMPLITUDE_UP_RESULT_ADDR, AMPLITUDE_CAL_HIGH_ADDR,
    AMPLITUDE_DOWN_RESULT_ADDR, AMPLITUDE_CAL_LOW_ADDR};
  localparam ccs_op_e AMP_OP [4] = '{OP_AMP_UP, OP_CAL_HIGH, OP_AMP_DOWN, OP_CAL_LOW};
  logic clk, reset_n, wr_en, rd_en, seq_trigger, stall, irq;
  logic fast_osc_enable, fast_osc_ready, ring_cal_req, ring_cal_done, meas_req, meas_done;
  logic    [ADDR_W-1:0] addr;
  logic    [DATA_W-1:0] wr_data, rd_data, meas_result;
  ccs_op_e              meas_op;
  logic    [SPAN_W-1:0] slow_period_span;
  logic    [PD_W-1:0]   peak_detect_last_wave;
  logic    [ZCD_W-1:0]  zero_cross_threshold;
  int                   n_fail, n_compared, i;
  ccs_chip_calibration_scheduler ccs_chip_calibration_scheduler_inst (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .irq(irq), .seq_trigger(seq_trigger), .fast_osc_enable(fast_osc_enable),
    .fast_osc_ready(fast_osc_ready), .ring_cal_req(ring_cal_req), .ring_cal_done(ring_cal_done),
    .meas_req(meas_req), .meas_op(meas_op), .slow_period_span(slow_period_span), .meas_done(meas_done),
    .meas_result(meas_result), .peak_detect_last_wave(peak_detect_last_wave),
    .zero_cross_threshold(zero_cross_threshold));
  ccs_frontend_model ccs_frontend_model_inst (
    .clk(clk), .reset_n(reset_n), .stall(stall), .fast_osc_enable(fast_osc_enable),
    .ring_cal_req(ring_cal_req), .meas_req(meas_req), .meas_op(meas_op), .fast_osc_ready(fast_osc_ready),
    .ring_cal_done(ring_cal_done), .meas_done(meas_done), .meas_result(meas_result));
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task automatic trig();
    @(posedge clk);
    seq_trigger <= 1'b1;
    @(posedge clk);
    seq_trigger <= 1'b0;
  endtask
  // A job must start within a short window when run is set, must not start when it is clear, and must end within a bounded time.
  task automatic job(input bit run);
    int k;
    // Outputs are looked at just after the edge, once the design's registers have settled.
    for (k = 0; k < 20 && fast_osc_enable !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(fast_osc_enable), 32'(run));
    for (k = 0; k < 200 && fast_osc_enable !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 200) begin
      n_fail++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {reset_n, wr_en, rd_en, seq_trigger, stall, n_fail, n_compared} = '0;
    addr = '0;
    wr_data = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    job(1'b1);
    rd(ZERO_CROSS_THRESHOLD_ADDR, 32'(OP_OFFSET_CAL));
    wr(ZERO_CROSS_THRESHOLD_ADDR, 32'h5a);
    rd(ZERO_CROSS_THRESHOLD_ADDR, 32'h5a);
    chk(32'(zero_cross_threshold), 32'h5a);
    rd(IRQ_STATUS_ADDR, 32'h8);
    chk(32'(irq), 32'h0);
    wr(IRQ_MASK_ADDR, 32'hf);
    #1 chk(32'(irq), 32'h1);
    wr(IRQ_STATUS_ADDR, 32'h8);
    stall <= 1'b1;
    #1 chk(32'(irq), 32'h0);
    wr(COMMAND_ADDR, 32'h1);
    repeat (10) @(posedge clk);
    stall <= 1'b0;
    #1 chk(32'(ring_cal_req), 32'h1);
    job(1'b1);
    rd(FAST_CLOCK_CAL_RESULT_ADDR, NOMINAL);
    rd(IRQ_STATUS_ADDR, 32'h1);
    chk(32'(irq), 32'h1);
    wr(FAST_CLOCK_CAL_RESULT_ADDR, 32'h0);
    rd(FAST_CLOCK_CAL_RESULT_ADDR, NOMINAL);
    rd(10'h3ff, 32'h0);
    wr(IRQ_STATUS_ADDR, 32'hf);
    rd(IRQ_STATUS_ADDR, 32'h0);
    wr(CLOCK_POWER_CONFIG_ADDR, 32'h2);
    for (i = 0; i < 4; i++) begin
      trig();
      job(i[0]);
    end
    wr(CLOCK_POWER_CONFIG_ADDR, 32'h0);
    wr(AMPLITUDE_CONFIG_ADDR, 32'h0000_11f1);
    #1 chk(32'(peak_detect_last_wave), 32'h1f);
    trig();
    job(1'b1);
    for (i = 0; i < 4; i++)
      rd(AMP_ADDR[i], NOMINAL + 32'(AMP_OP[i]));
    // The two fast-clock jobs of the interval loop left their update flag standing as well.
    rd(IRQ_STATUS_ADDR, 32'h7);
    wr(AMPLITUDE_CONFIG_ADDR, 32'h0000_2001);
    for (i = 0; i < 2; i++) begin
      wr(IRQ_STATUS_ADDR, 32'hf);
      trig();
      job(1'b1);
      rd(IRQ_STATUS_ADDR, i ? 32'h6 : 32'h2);
    end
    wr(AMPLITUDE_CONFIG_ADDR, 32'h0);
    wr(FRONTEND_CAL_CONFIG_ADDR, 32'h1);
    trig();
    job(1'b1);
    rd(ZERO_CROSS_THRESHOLD_ADDR, 32'(OP_OFFSET_CAL));
    chk(32'(zero_cross_threshold), 32'(OP_OFFSET_CAL));
    close_out();
  end
endmodule
`default_nettype wire
